// File: pswb_consts.vh
// constants for the pixel shift and white balance stage
`ifndef PSWB_CONSTS_VH
`define PSWB_CONSTS_VH

// register byte offsets
`define PSWB_OFS_CTRL 5'h00
`define PSWB_OFS_RATIO 5'h04
`define PSWB_OFS_RATIO_R 5'h08
`define PSWB_OFS_RATIO_G 5'h0c
`define PSWB_OFS_RATIO_B 5'h10
`define PSWB_OFS_STATUS 5'h14

// control fields
`define PSWB_CTRL_DEPTH8 0
`define PSWB_CTRL_SHIFT_LO 4
`define PSWB_CTRL_SHIFT_HI 6
`define PSWB_CTRL_SEL_LO 8
`define PSWB_CTRL_SEL_HI 9

// status fields
`define PSWB_STAT_EMPTY 0
`define PSWB_STAT_FULL 1
`define PSWB_STAT_LVL_LO 4
`define PSWB_STAT_LVL_HI 8
`define PSWB_STAT_SAT 16

// colour codes
`define PSWB_COL_RED 2'h0
`define PSWB_COL_GREEN 2'h1
`define PSWB_COL_BLUE 2'h2

// ratio format: unsigned q2.8, one is 256
`define PSWB_RATIO_W 10
`define PSWB_RATIO_ONE 10'h100
`define PSWB_RATIO_MAX 10'h3fb
`define PSWB_ROUND 22'h00_0080
`define PSWB_FRAC 8

// shift
`define PSWB_SHIFT_MAX 3'h4
`define PSWB_SHIFT_OFF 3'h0

// pixel widths and codes
`define PSWB_PIX_W 12
`define PSWB_PIX_MAX 12'hfff
`define PSWB_PIX8_MAX 8'hff

// buffering
`define PSWB_FIFO_DEPTH 16
`define PSWB_LVL_W 5
`define PSWB_RDY_LEVEL 5'h0c

`endif

// File: pswb_fifo.v
// output fifo with registered read data
`timescale 1ns/1ps
module pswb_fifo #(
    parameter W = 14,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // draining side
    output reg out_valid_q,
    input wire out_ready,
    output reg [W-1:0] out_data_q,
    // occupancy of the storage array
    output reg [AW:0] level_q
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    wire push;
    wire pop;

    // storage is full when level reaches depth
    assign in_ready = (level_q != DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    // refill the output register whenever it is empty or being taken
    assign pop = (level_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);

    // storage array has no reset, pointers protect it
    always @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end

    // pointers, level and output register
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            level_q <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
            out_data_q <= {W{1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
                out_data_q <= mem[rd_ptr_q];
                out_valid_q <= 1'b1;
            end
            else if (out_ready)
                out_valid_q <= 1'b0;
            if (push && !pop)
                level_q <= level_q + {{AW{1'b0}}, 1'b1};
            else if (pop && !push)
                level_q <= level_q - {{AW{1'b0}}, 1'b1};
        end
    end
endmodule

// File: pswb_top.v
// pixel white balance gain and digital shift stage with register slave
`timescale 1ns/1ps
`include "pswb_consts.vh"
module pswb_top (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // avalon-mm register slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata_q,
    output reg avs_waitrequest_q,
    // adc sample stream in
    input wire pix_in_valid,
    output reg pix_in_ready_q,
    input wire [11:0] pix_in_data,
    input wire [1:0] pix_in_colour,
    // pixel stream out
    output wire pix_out_valid,
    input wire pix_out_ready,
    output wire [11:0] pix_out_data,
    output wire [1:0] pix_out_colour
);
    // control state
    reg depth8_q;
    reg [2:0] shift_q;
    reg [1:0] sel_q;
    reg sat_seen_q;
    wire [`PSWB_RATIO_W-1:0] ratio_w [0:2];

    // bus decode
    wire bus_req;
    wire wr_do;
    wire [4:0] ofs;
    wire hit_ctrl;
    wire hit_ratio;
    wire [`PSWB_RATIO_W-1:0] wr_ratio;
    wire [2:0] wr_shift;
    reg [31:0] rd_mux;

    // pipeline
    reg s1_valid_q;
    reg [21:0] s1_prod_q;
    reg [1:0] s1_col_q;
    reg s2_valid_q;
    reg [11:0] s2_pix_q;
    reg [1:0] s2_col_q;
    reg s2_sat_q;
    reg [`PSWB_RATIO_W-1:0] cur_ratio;
    wire [21:0] prod_rnd;
    wire [13:0] gained;
    wire [11:0] gained_sat;
    wire [15:0] shifted;
    wire win_over;
    reg [11:0] shaped;

    // fifo links
    wire fifo_in_ready;
    wire [`PSWB_LVL_W-1:0] fifo_level;
    wire [13:0] fifo_out_data;

    assign bus_req = avs_read || avs_write;
    // a write takes effect only at the edge where waitrequest is seen low
    assign wr_do = avs_write && !avs_waitrequest_q;
    assign ofs = {avs_address[4:2], 2'b00};
    assign hit_ctrl = (ofs == `PSWB_OFS_CTRL);
    assign hit_ratio = (ofs == `PSWB_OFS_RATIO);
    // oversized ratios clip to the top of the accepted range
    assign wr_ratio = (avs_writedata[`PSWB_RATIO_W-1:0] > `PSWB_RATIO_MAX) ?
                      `PSWB_RATIO_MAX : avs_writedata[`PSWB_RATIO_W-1:0];
    assign wr_shift = avs_writedata[`PSWB_CTRL_SHIFT_HI:`PSWB_CTRL_SHIFT_LO];

    // one ratio register per colour, each written only when selected
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_ratio
            reg [`PSWB_RATIO_W-1:0] ratio_q;
            always @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                    ratio_q <= `PSWB_RATIO_ONE;
                else if (wr_do && hit_ratio && (avs_byteenable[1:0] == 2'b11)
                         && (sel_q == gi[1:0]))
                    ratio_q <= wr_ratio;
            end
            assign ratio_w[gi] = ratio_q;
        end
    endgenerate

    // control register: depth, shift and colour selector
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            depth8_q <= 1'b0;
            shift_q <= `PSWB_SHIFT_OFF;
            sel_q <= `PSWB_COL_RED;
        end
        else if (wr_do && hit_ctrl)
        begin
            if (avs_byteenable[0])
            begin
                depth8_q <= avs_writedata[`PSWB_CTRL_DEPTH8];
                // shift codes above four are ignored and the old one kept
                if (wr_shift <= `PSWB_SHIFT_MAX)
                    shift_q <= wr_shift;
            end
            // selector code three is no colour and is refused
            if (avs_byteenable[1] &&
                (avs_writedata[`PSWB_CTRL_SEL_HI:`PSWB_CTRL_SEL_LO] != 2'h3))
                sel_q <= avs_writedata[`PSWB_CTRL_SEL_HI:`PSWB_CTRL_SEL_LO];
        end
    end

    // read data mux, unmapped offsets read zero
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (ofs)
            `PSWB_OFS_CTRL:
            begin
                rd_mux[`PSWB_CTRL_DEPTH8] = depth8_q;
                rd_mux[`PSWB_CTRL_SHIFT_HI:`PSWB_CTRL_SHIFT_LO] = shift_q;
                rd_mux[`PSWB_CTRL_SEL_HI:`PSWB_CTRL_SEL_LO] = sel_q;
            end
            `PSWB_OFS_RATIO:
                rd_mux[`PSWB_RATIO_W-1:0] = ratio_w[sel_q];
            `PSWB_OFS_RATIO_R:
                rd_mux[`PSWB_RATIO_W-1:0] = ratio_w[0];
            `PSWB_OFS_RATIO_G:
                rd_mux[`PSWB_RATIO_W-1:0] = ratio_w[1];
            `PSWB_OFS_RATIO_B:
                rd_mux[`PSWB_RATIO_W-1:0] = ratio_w[2];
            `PSWB_OFS_STATUS:
            begin
                rd_mux[`PSWB_STAT_EMPTY] = (fifo_level == {`PSWB_LVL_W{1'b0}});
                rd_mux[`PSWB_STAT_FULL] = !fifo_in_ready;
                rd_mux[`PSWB_STAT_LVL_HI:`PSWB_STAT_LVL_LO] = fifo_level;
                rd_mux[`PSWB_STAT_SAT] = sat_seen_q;
            end
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // every access costs one wait cycle; read data is captured with it
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q <= 32'h0000_0000;
        end
        else if (bus_req && avs_waitrequest_q)
        begin
            avs_waitrequest_q <= 1'b0;
            avs_readdata_q <= rd_mux;
        end
        else
            avs_waitrequest_q <= 1'b1;
    end

    // sticky saturation flag, a new event beats a clear in the same cycle
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            sat_seen_q <= 1'b0;
        else if (s2_valid_q && s2_sat_q)
            sat_seen_q <= 1'b1;
        else if (wr_do && (ofs == `PSWB_OFS_STATUS) && avs_byteenable[2] &&
                 avs_writedata[`PSWB_STAT_SAT])
            sat_seen_q <= 1'b0;
    end

    // pick the ratio of the colour carried with the sample
    always @*
    begin
        case (pix_in_colour)
            `PSWB_COL_RED: cur_ratio = ratio_w[0];
            `PSWB_COL_GREEN: cur_ratio = ratio_w[1];
            `PSWB_COL_BLUE: cur_ratio = ratio_w[2];
            default: cur_ratio = `PSWB_RATIO_ONE;
        endcase
    end

    // stage 1: proportional gain multiply
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_valid_q <= 1'b0;
            s1_prod_q <= 22'h00_0000;
            s1_col_q <= `PSWB_COL_RED;
        end
        else
        begin
            s1_valid_q <= pix_in_valid && pix_in_ready_q;
            s1_prod_q <= pix_in_data * cur_ratio;
            s1_col_q <= pix_in_colour;
        end
    end

    // round to nearest, then clip to the largest twelve-bit code
    assign prod_rnd = s1_prod_q + `PSWB_ROUND;
    assign gained = prod_rnd[21:`PSWB_FRAC];
    assign gained_sat = (gained > {2'b00, `PSWB_PIX_MAX}) ?
                        `PSWB_PIX_MAX : gained[11:0];

    // shifting the window up is a multiply by two to the n
    assign shifted = {4'h0, gained_sat} << shift_q;
    // bits pushed past the top mean the window lost significant data
    assign win_over = |shifted[15:12];

    // shape the output word for the chosen depth
    always @*
    begin
        shaped = 12'h000;
        if (win_over)
            shaped = depth8_q ? {4'h0, `PSWB_PIX8_MAX} : `PSWB_PIX_MAX;
        else if (depth8_q)
            shaped = {4'h0, shifted[11:4]};
        else
            shaped = shifted[11:0];
    end

    // stage 2: register the shaped pixel for the fifo
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s2_valid_q <= 1'b0;
            s2_pix_q <= 12'h000;
            s2_col_q <= `PSWB_COL_RED;
            s2_sat_q <= 1'b0;
        end
        else
        begin
            s2_valid_q <= s1_valid_q;
            s2_pix_q <= shaped;
            s2_col_q <= s1_col_q;
            s2_sat_q <= win_over;
        end
    end

    // input ready leaves room for the samples still in flight, so the
    // pipeline itself never has to stall; costs four entries of headroom
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pix_in_ready_q <= 1'b0;
        else
            pix_in_ready_q <= (fifo_level <= `PSWB_RDY_LEVEL);
    end

    // output buffer, data and colour travel together
    pswb_fifo #(
        .W(14),
        .DEPTH(`PSWB_FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(s2_valid_q && fifo_in_ready),
        .in_ready(fifo_in_ready),
        .in_data({s2_col_q, s2_pix_q}),
        .out_valid_q(pix_out_valid),
        .out_ready(pix_out_ready),
        .out_data_q(fifo_out_data),
        .level_q(fifo_level)
    );

    assign pix_out_data = fifo_out_data[11:0];
    assign pix_out_colour = fifo_out_data[13:12];
endmodule

// File: pswb_top_asserts.sv
// port assertions for the pixel shift and white balance stage
`timescale 1ns/1ps
module pswb_top_asserts (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // register bus
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata_q,
    input wire avs_waitrequest_q,
    // pixel streams
    input wire pix_in_valid,
    input wire pix_in_ready_q,
    input wire pix_out_valid,
    input wire pix_out_ready,
    input wire [11:0] pix_out_data,
    input wire [1:0] pix_out_colour
);
    reg d8_q;
    wire ans = !avs_waitrequest_q;
    wire rd_ans = avs_read && ans;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // a request that still waits, and a sample taken
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest_q;
    endsequence
    sequence s_take;
        pix_in_valid && pix_in_ready_q;
    endsequence
    // depth as last written; assumes all byte lanes enabled
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            d8_q <= 1'b0;
        else if (avs_write && ans && avs_address[4:2] == 3'h0)
            d8_q <= avs_writedata[0];
    end
    chk_bus_answer: assert property (s_req |=> ans)
        else $error("register request not answered after one wait");
    chk_wait_pulse: assert property (ans |=> !ans)
        else $error("waitrequest low for more than one cycle");
    chk_ratio_range: assert property (rd_ans && avs_address[4:2] != 3'h0
        && avs_address[4:2] < 3'h5 |-> avs_readdata_q <= 32'h0000_03fb)
        else $error("ratio read back above the top of its range");
    chk_shift_range: assert property (rd_ans && avs_address[4:2] == 3'h0
        |-> avs_readdata_q[6:4] <= 3'h4)
        else $error("shift field holds a code above four");
    chk_out_hold: assert property (pix_out_valid && !pix_out_ready
        |=> pix_out_valid && $stable(pix_out_data) && $stable(pix_out_colour))
        else $error("output pixel changed while stalled");
    chk_out_latency: assert property (s_take |-> ##[0:4] pix_out_valid)
        else $error("taken sample did not reach the output in time");
    chk_ready_back: assert property (!pix_in_ready_q && !pix_out_valid |=> pix_in_ready_q)
        else $error("input ready stayed low with nothing buffered");
    chk_depth8_top: assert property (pix_out_valid && d8_q
        |-> pix_out_data[11:8] == 4'h0)
        else $error("eight-bit pixel has upper bits set");
endmodule
bind pswb_top pswb_top_asserts pswb_top_asserts_inst (.clk_sys, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata_q, .avs_waitrequest_q,
    .pix_in_valid, .pix_in_ready_q, .pix_out_valid, .pix_out_ready, .pix_out_data,
    .pix_out_colour);

// File: pswb_sink.sv
// downstream pixel sink that answers promptly, slowly or not at all
`timescale 1ns/1ps
module pswb_sink (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // 0 prompt, 1 random stalls, 2 held off
    input wire [1:0] mode,
    // pixel handshake
    output reg pix_out_ready
);
    integer seed = 32'h0000_01d3;
    reg [31:0] rv;
    // own seed, so stalls do not disturb the bench's sample stream
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pix_out_ready <= 1'b0;
        else
        begin
            rv = $random(seed);
            pix_out_ready <= mode == 2'h0 || (mode == 2'h1 && rv[1:0] == 2'h0);
        end
    end
endmodule

// File: pswb_top_tb.sv
// self-checking bench for the pixel shift and white balance stage
`timescale 1ns/1ps
`include "pswb_consts.vh"
module pswb_top_tb;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg [4:0] avs_address = 5'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0000_0000;
    wire [31:0] avs_readdata_q;
    wire avs_waitrequest_q;
    reg pix_in_valid = 1'b0;
    wire pix_in_ready_q;
    reg [11:0] pix_in_data = 12'h000;
    reg [1:0] pix_in_colour = 2'h0;
    wire pix_out_valid;
    wire pix_out_ready;
    wire [11:0] pix_out_data;
    wire [1:0] pix_out_colour;
    reg [1:0] sink_mode = 2'h0;
    integer seed = 32'h482f;
    integer miscompares = 0;
    integer checked = 0;
    integer i;
    reg [9:0] rat [0:3];
    reg [2:0] sh = 3'h0;
    reg d8 = 1'b0;
    reg [13:0] exq [$];
    reg [31:0] q;
    reg [31:0] rv;

    always #2 clk_sys = ~clk_sys;

    pswb_top pswb_top_inst (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
        .avs_writedata(avs_writedata), .avs_readdata_q(avs_readdata_q),
        .avs_waitrequest_q(avs_waitrequest_q), .pix_in_valid(pix_in_valid),
        .pix_in_ready_q(pix_in_ready_q), .pix_in_data(pix_in_data),
        .pix_in_colour(pix_in_colour), .pix_out_valid(pix_out_valid),
        .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data),
        .pix_out_colour(pix_out_colour));
    pswb_sink pswb_sink_inst (.clk_sys(clk_sys), .rstn(rstn), .mode(sink_mode),
        .pix_out_ready(pix_out_ready));

    task results;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task automatic check(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // one register access; the request stands until waitrequest is seen low
    task bus(input [4:0] a, input w, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys);
            avs_address <= a;
            avs_write <= w;
            avs_read <= !w;
            avs_writedata <= d;
            n = 0;
            @(posedge clk_sys);
            while (avs_waitrequest_q !== 1'b0 && n < 20)
            begin
                n = n + 1;
                @(posedge clk_sys);
            end
            q = avs_readdata_q;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            if (n == 20)
            begin
                miscompares = miscompares + 1;
                results;
            end
        end
    endtask

    // expected pixel: rounded gain clipped at 4095, then window shift with overflow
    function [11:0] model(input [11:0] d, input [9:0] r);
        reg [21:0] p;
        reg [15:0] s;
        begin
            p = (d * r + `PSWB_ROUND) >> `PSWB_FRAC;
            s = (p > 22'h00_0fff ? 16'h0fff : p[15:0]) << sh;
            if (s[15:12] != 4'h0)
                model = d8 ? 12'h0ff : 12'hfff;
            else
                model = d8 ? {4'h0, s[11:4]} : s[11:0];
        end
    endfunction

    // random samples, data masked; gives up quietly after lim cycles
    task stream(input integer n, input [11:0] mask, input integer lim);
        integer k;
        integer c;
        begin
            k = 0;
            c = 0;
            while (k < n && c < lim)
            begin
                @(posedge clk_sys);
                c = c + 1;
                if (pix_in_valid && pix_in_ready_q === 1'b1)
                begin
                    exq.push_back({pix_in_colour, model(pix_in_data, rat[pix_in_colour])});
                    k = k + 1;
                end
                rv = $random(seed);
                pix_in_valid <= k < n && c < lim && rv[15:14] != 2'h0;
                pix_in_data <= rv[11:0] & mask;
                pix_in_colour <= rv[13:12];
            end
        end
    endtask

    // wait for every taken sample to leave before touching the settings
    task drain;
        integer n;
        begin
            n = 0;
            while (exq.size() != 0 && n < 500)
            begin
                @(posedge clk_sys);
                n = n + 1;
            end
            if (n == 500)
            begin
                miscompares = miscompares + 1;
                results;
            end
        end
    endtask

    // scoreboard on the output handshake
    always @(posedge clk_sys)
        if (rstn && pix_out_valid === 1'b1 && pix_out_ready)
            check({pix_out_colour, pix_out_data}, exq.pop_front());

    initial
    begin
        for (i = 0; i < 4; i = i + 1)
            rat[i] = `PSWB_RATIO_ONE;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        bus(`PSWB_OFS_CTRL, 1'b0, 32'h0000_0000);
        check(q, 32'h0000_0000);
        bus(`PSWB_OFS_STATUS, 1'b0, 32'h0000_0000);
        check(q & 32'h0000_0003, 32'h0000_0001);
        // each colour chosen first, then its ratio; red overdriven to clip
        for (i = 0; i < 3; i = i + 1)
        begin
            rv = $random(seed);
            rv[9:0] = i == 0 ? 10'h3ff : i == 1 ? `PSWB_RATIO_ONE : rv[9:0];
            rat[i] = rv[9:0] > `PSWB_RATIO_MAX ? `PSWB_RATIO_MAX : rv[9:0];
            bus(`PSWB_OFS_RATIO_R + {i[2:0], 2'b00}, 1'b0, 32'h0000_0000);
            check(q, {22'h0, `PSWB_RATIO_ONE});
            bus(`PSWB_OFS_CTRL, 1'b1, {22'h0, i[1:0], 8'h00});
            bus(`PSWB_OFS_RATIO, 1'b1, {22'h0, rv[9:0]});
        end
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(`PSWB_OFS_RATIO_R + {i[2:0], 2'b00}, 1'b0, 32'h0000_0000);
            check(q, {22'h0, rat[i]});
        end
        bus(`PSWB_OFS_CTRL, 1'b1, 32'h0000_0300);
        bus(`PSWB_OFS_CTRL, 1'b0, 32'h0000_0000);
        check(q, 32'h0000_0200);
        // both depths and shift codes 0 to 4, full range and window-sized samples
        for (i = 0; i < 10; i = i + 1)
        begin
            d8 = i > 4;
            sh = i % 5;
            sink_mode <= {1'b0, i[0]};
            bus(`PSWB_OFS_CTRL, 1'b1, {22'h0, 2'h2, 1'b0, sh, 3'h0, d8});
            bus(`PSWB_OFS_CTRL, 1'b0, 32'h0000_0000);
            check(q, {22'h0, 2'h2, 1'b0, sh, 3'h0, d8});
            stream(24, 12'hfff, 2000);
            stream(24, 12'hfff >> sh, 2000);
            drain;
            // full-range samples overflow any shifted window, never the unshifted one
            bus(`PSWB_OFS_STATUS, 1'b0, 32'h0000_0000);
            check({31'h0, q[`PSWB_STAT_SAT]}, {31'h0, sh != 3'h0});
            bus(`PSWB_OFS_STATUS, 1'b1, 32'h0001_0000);
        end
        bus(`PSWB_OFS_CTRL, 1'b1, 32'h0000_0251);
        bus(`PSWB_OFS_CTRL, 1'b0, 32'h0000_0000);
        check(q, 32'h0000_0241);
        // fill the buffer against a stopped sink, then drain it with stalls
        sink_mode <= 2'h2;
        stream(40, 12'h0ff, 60);
        @(negedge clk_sys);
        check({31'h0, pix_in_ready_q}, 32'h0000_0000);
        bus(`PSWB_OFS_STATUS, 1'b0, 32'h0000_0000);
        check({31'h0, q[8:4] > 5'h0c}, 32'h0000_0001);
        sink_mode <= 2'h1;
        drain;
        bus(`PSWB_OFS_STATUS, 1'b0, 32'h0000_0000);
        check(q & 32'h0000_0003, 32'h0000_0001);
        // unmapped place reads zero and ignores writes
        bus(5'h18, 1'b1, 32'hffff_ffff);
        bus(5'h18, 1'b0, 32'h0000_0000);
        check(q, 32'h0000_0000);
        results;
    end
endmodule
